// *** verilog/fiber_readout_defines.vh ***
`ifndef FIBER_READOUT_DEFINES_VH
`define FIBER_READOUT_DEFINES_VH
// APB register byte offsets
`define REG_CONTROL 12'h000
`define REG_THRESHOLD 12'h004
`define REG_INJECT_LO 12'h008
`define REG_INJECT_HI 12'h00C
`define REG_STATUS 12'h010
`define REG_CHIP_ID 12'h014
// Control field positions
`define CTL_GAIN_LSB 0
`define CTL_GAIN_MSB 3
`define CTL_INJECT_EN 4
`define CTL_TAP_LSB 8
`define CTL_TAP_MSB 12
// Reset values
`define CONTROL_RESET 32'h00001F00
`define THRESHOLD_RESET 8'h80
// Timing figures
`define CLOCK_MHZ 100
`define COLLECT_NS 75
`define TOGGLE_NS 25
`define MUX_KHZ 7600
`define ADC_INPUTS 2
`define LINK_KHZ 53000
// Readout bus mode codes
`define MODE_CAPTURE 2'h0
`define MODE_DIGITIZE 2'h1
`define MODE_READOUT 2'h2
`define MODE_IDLE 2'h3
// Float format: 3-bit exponent, 7-bit mantissa
`define MANT_BITS 7
`define EXP_BITS 3
`endif

// *** verilog/fiber_frontend_readout_emulator.v ***
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "fiber_readout_defines.vh"
module fiber_frontend_readout_emulator #(
	parameter CHANNELS = 64,
	parameter DEPTH = 32,
	parameter ANALOG_DEPTH = 47,
	parameter [7:0] CHIP_ID = 8'h5A
) (
	// Clock and reset
	input wire clock,
	input wire resetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Readout bus mode and crossing
	input wire [1:0] bus_mode,
	input wire crossing,
	input wire readout_step,
	output reg [7:0] readout_data,
	output reg readout_valid,
	// Front-end chip control
	output reg amp_reset,
	output wire [3:0] gain_select,
	output wire [7:0] threshold,
	output wire [63:0] inject_mask,
	output reg pipeline_freeze,
	output reg [3:0] mux_select,
	output reg mux_clock,
	// Discriminator lines, two bits each
	input wire [31:0] disc_lines,
	output reg disc_phase,
	// ADC inputs
	input wire [9:0] adc_a,
	input wire [9:0] adc_b,
	output reg adc_convert,
	// Trigger packets
	output reg [9:0] trig_packet,
	output reg trig_packet_valid
);
	localparam COLLECT_CYC = (`COLLECT_NS * `CLOCK_MHZ + 999) / 1000;
	localparam TOGGLE_CYC = (`TOGGLE_NS * `CLOCK_MHZ + 999) / 1000;
	localparam MUX_DIV = (`CLOCK_MHZ * 1000 + `MUX_KHZ - 1) / `MUX_KHZ;
	localparam LINK_DIV = (`CLOCK_MHZ * 1000 + `LINK_KHZ - 1) / `LINK_KHZ;
	// Each ADC alternates its two inputs, so converts run at twice the mux rate
	localparam CONV_DIV = MUX_DIV / `ADC_INPUTS;
	localparam PACKETS = 8;
	localparam SEQ_IDLE = 5'h01;
	localparam SEQ_COLLECT = 5'h02;
	localparam SEQ_LOW = 5'h04;
	localparam SEQ_HIGH = 5'h08;
	localparam SEQ_DONE = 5'h10;
	localparam DIG_IDLE = 3'h1;
	localparam DIG_RUN = 3'h2;
	localparam DIG_DONE = 3'h4;

	// Synchronisers for off-chip inputs
	reg [1:0] mode_s1_q, mode_s2_q, mode_last_q;
	reg cross_s1_q, cross_s2_q, cross_last_q;
	reg step_s1_q, step_s2_q, step_last_q;
	reg [31:0] disc_s1_q, disc_s2_q;
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			mode_s1_q <= `MODE_IDLE;
			mode_s2_q <= `MODE_IDLE;
			mode_last_q <= `MODE_IDLE;
			cross_s1_q <= 1'b0;
			cross_s2_q <= 1'b0;
			cross_last_q <= 1'b0;
			step_s1_q <= 1'b0;
			step_s2_q <= 1'b0;
			step_last_q <= 1'b0;
			disc_s1_q <= 32'h00000000;
			disc_s2_q <= 32'h00000000;
		end
		else
		begin
			mode_s1_q <= bus_mode;
			mode_s2_q <= mode_s1_q;
			mode_last_q <= mode_s2_q;
			cross_s1_q <= crossing;
			cross_s2_q <= cross_s1_q;
			cross_last_q <= cross_s2_q;
			step_s1_q <= readout_step;
			step_s2_q <= step_s1_q;
			step_last_q <= step_s2_q;
			disc_s1_q <= disc_lines;
			disc_s2_q <= disc_s1_q;
		end
	end
	wire cross_edge = cross_s2_q & ~cross_last_q;
	wire step_edge = step_s2_q & ~step_last_q;
	wire capture_phase = (mode_s2_q == `MODE_CAPTURE);
	wire to_digitize = (mode_s2_q == `MODE_DIGITIZE) && (mode_last_q == `MODE_CAPTURE);
	wire in_readout = (mode_s2_q == `MODE_READOUT);

	// Registers
	reg [31:0] control_q;
	reg [7:0] threshold_q;
	reg [63:0] inject_q;
	reg [6:0] status_bits;
	wire apb_write = psel & penable & pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign gain_select = control_q[`CTL_GAIN_MSB:`CTL_GAIN_LSB];
	assign threshold = threshold_q;
	assign inject_mask = control_q[`CTL_INJECT_EN] ? inject_q : 64'h0;
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			control_q <= `CONTROL_RESET;
			threshold_q <= `THRESHOLD_RESET;
			inject_q <= 64'h0;
		end
		else if (apb_write)
		begin
			case (paddr)
				`REG_CONTROL: control_q <= pwdata;
				`REG_THRESHOLD: threshold_q <= pwdata[7:0];
				`REG_INJECT_LO: inject_q[31:0] <= pwdata;
				`REG_INJECT_HI: inject_q[63:32] <= pwdata;
				default: control_q <= control_q;
			endcase
		end
	end
	// Read data captured in the setup cycle, stable through access
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			prdata <= 32'h00000000;
		else if (psel && !penable)
		begin
			case (paddr)
				`REG_CONTROL: prdata <= control_q;
				`REG_THRESHOLD: prdata <= {24'h0, threshold_q};
				`REG_INJECT_LO: prdata <= inject_q[31:0];
				`REG_INJECT_HI: prdata <= inject_q[63:32];
				`REG_STATUS: prdata <= {25'h0, status_bits};
				`REG_CHIP_ID: prdata <= {24'h0, CHIP_ID};
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// Crossing sequencer: collect, then two demux slots
	reg [4:0] seq_q;
	reg [7:0] seq_cnt_q;
	reg [63:0] disc_word_q;
	reg word_ready_q;
	reg [7:0] cross_count_q;
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			seq_q <= SEQ_IDLE;
			seq_cnt_q <= 8'h00;
			disc_word_q <= 64'h0;
			word_ready_q <= 1'b0;
			amp_reset <= 1'b0;
			disc_phase <= 1'b0;
			cross_count_q <= 8'h00;
		end
		else
		begin
			word_ready_q <= 1'b0;
			case (seq_q)
				SEQ_IDLE:
				begin
					amp_reset <= 1'b0;
					if (cross_edge && capture_phase)
					begin
						seq_q <= SEQ_COLLECT;
						seq_cnt_q <= COLLECT_CYC[7:0];
						disc_phase <= 1'b0;
					end
				end
				SEQ_COLLECT:
				begin
					if (seq_cnt_q == 8'h01)
					begin
						seq_q <= SEQ_LOW;
						seq_cnt_q <= TOGGLE_CYC[7:0];
					end
					else
						seq_cnt_q <= seq_cnt_q - 8'h01;
				end
				SEQ_LOW:
				begin
					if (seq_cnt_q == 8'h01)
					begin
						disc_word_q[31:0] <= disc_s2_q;
						disc_phase <= 1'b1;
						seq_q <= SEQ_HIGH;
						seq_cnt_q <= TOGGLE_CYC[7:0];
					end
					else
						seq_cnt_q <= seq_cnt_q - 8'h01;
				end
				SEQ_HIGH:
				begin
					if (seq_cnt_q == 8'h01)
					begin
						disc_word_q[63:32] <= disc_s2_q;
						word_ready_q <= 1'b1;
						seq_q <= SEQ_DONE;
					end
					else
						seq_cnt_q <= seq_cnt_q - 8'h01;
				end
				SEQ_DONE:
				begin
					amp_reset <= 1'b1;
					disc_phase <= 1'b0;
					cross_count_q <= cross_count_q + 8'h01;
					seq_q <= SEQ_IDLE;
				end
				default: seq_q <= SEQ_IDLE;
			endcase
		end
	end

	// Packetiser: 64 data + 7 status bits into 10-bit packets
	reg [79:0] pkt_shift_q;
	reg [3:0] pkt_left_q;
	reg [7:0] link_div_q;
	always @*
	begin
		status_bits = {capture_phase, pipeline_freeze, in_readout, cross_count_q[3:0]};
	end
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			pkt_shift_q <= 80'h0;
			pkt_left_q <= 4'h0;
			link_div_q <= 8'h00;
			trig_packet <= 10'h000;
			trig_packet_valid <= 1'b0;
		end
		else
		begin
			trig_packet_valid <= 1'b0;
			link_div_q <= (link_div_q == LINK_DIV[7:0] - 8'h01) ? 8'h00 : link_div_q + 8'h01;
			if (word_ready_q)
			begin
				pkt_shift_q <= {9'h000, status_bits, disc_word_q};
				pkt_left_q <= PACKETS[3:0];
			end
			else if (link_div_q == 8'h00 && pkt_left_q != 4'h0)
			begin
				trig_packet <= pkt_shift_q[9:0];
				trig_packet_valid <= 1'b1;
				pkt_shift_q <= {10'h000, pkt_shift_q[79:10]};
				pkt_left_q <= pkt_left_q - 4'h1;
			end
		end
	end

	// Discriminator history RAM
	reg [CHANNELS-1:0] hist_mem [0:DEPTH-1];
	reg [4:0] wr_ptr_q;
	reg [4:0] frozen_ptr_q;
	wire [4:0] tap = control_q[`CTL_TAP_MSB:`CTL_TAP_LSB];
	always @(posedge clock)
	begin
		if (word_ready_q)
			hist_mem[wr_ptr_q] <= disc_word_q;
	end
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_ptr_q <= 5'h00;
			frozen_ptr_q <= 5'h00;
		end
		else
		begin
			if (word_ready_q)
				wr_ptr_q <= wr_ptr_q + 5'h01;
			if (to_digitize)
				frozen_ptr_q <= wr_ptr_q - tap;
		end
	end

	// Digitizer: four muxes, two dual ADCs
	reg [2:0] dig_q;
	reg [7:0] mux_div_q;
	reg [4:0] dig_step_q;
	reg [9:0] float_mem [0:CHANNELS-1];
	function [9:0] to_float;
		input [9:0] raw;
		integer i;
		reg [2:0] e;
		begin
			e = 3'h0;
			for (i = 7; i <= 9; i = i + 1)
				if (raw[i])
					e = i[2:0] - 3'h6;
			// Seven bits from the leading one down, or bits 6:0 when no bit above 6 is set
			to_float = {e, raw[e[1:0] +: 7]};
		end
	endfunction
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			dig_q <= DIG_IDLE;
			mux_div_q <= 8'h00;
			dig_step_q <= 5'h00;
			pipeline_freeze <= 1'b0;
			mux_select <= 4'h0;
			mux_clock <= 1'b0;
			adc_convert <= 1'b0;
		end
		else
		begin
			adc_convert <= 1'b0;
			mux_clock <= 1'b0;
			case (dig_q)
				DIG_IDLE:
				begin
					if (to_digitize)
					begin
						pipeline_freeze <= 1'b1;
						dig_q <= DIG_RUN;
						dig_step_q <= 5'h00;
						mux_div_q <= 8'h00;
						mux_select <= 4'h0;
					end
					else if (capture_phase)
						pipeline_freeze <= 1'b0;
				end
				DIG_RUN:
				begin
					if (mux_div_q == CONV_DIV[7:0] - 8'h01)
					begin
						mux_div_q <= 8'h00;
						adc_convert <= 1'b1;
						mux_clock <= 1'b1;
						dig_step_q <= dig_step_q + 5'h01;
						mux_select <= dig_step_q[4:1] + {3'h0, dig_step_q[0]};
						if (dig_step_q == 5'h1F)
							dig_q <= DIG_DONE;
					end
					else
						mux_div_q <= mux_div_q + 8'h01;
				end
				DIG_DONE:
				begin
					if (capture_phase)
					begin
						dig_q <= DIG_IDLE;
						pipeline_freeze <= 1'b0;
					end
				end
				default: dig_q <= DIG_IDLE;
			endcase
		end
	end
	// Each convert: A sample goes to mux pair, B to the other pair
	wire [5:0] slot_a = {dig_step_q[0], 1'b0, dig_step_q[4:1]};
	wire [5:0] slot_b = {dig_step_q[0], 1'b1, dig_step_q[4:1]};
	always @(posedge clock)
	begin
		if (dig_q == DIG_RUN && mux_div_q == CONV_DIV[7:0] - 8'h01)
		begin
			float_mem[slot_a] <= to_float(adc_a);
			float_mem[slot_b] <= to_float(adc_b);
		end
	end

	// Readout emulation: id, status, then per channel id, disc, float
	reg [8:0] rd_idx_q;
	// Channel bytes start after id and status
	wire [8:0] rd_off = rd_idx_q - 9'h002;
	wire [5:0] rd_ch = rd_off[7:2];
	wire [CHANNELS-1:0] rd_disc = hist_mem[frozen_ptr_q];
	wire [9:0] rd_float = float_mem[rd_ch];
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			rd_idx_q <= 9'h000;
			readout_data <= 8'h00;
			readout_valid <= 1'b0;
		end
		else
		begin
			readout_valid <= 1'b0;
			if (!in_readout)
				rd_idx_q <= 9'h000;
			else if (step_edge && rd_idx_q != 9'h102)
			begin
				readout_valid <= 1'b1;
				rd_idx_q <= rd_idx_q + 9'h001;
				if (rd_idx_q == 9'h000)
					readout_data <= CHIP_ID;
				else if (rd_idx_q == 9'h001)
					readout_data <= {1'b0, status_bits};
				else
				begin
					case (rd_off[1:0])
						2'h0: readout_data <= {2'h0, rd_ch};
						2'h1: readout_data <= {7'h00, rd_disc[rd_ch]};
						2'h2: readout_data <= {6'h00, rd_float[9:8]};
						default: readout_data <= rd_float[7:0];
					endcase
				end
			end
		end
	end
endmodule // fiber_frontend_readout_emulator

// *** tb/fe_chip_model.sv ***
`timescale 1ns/10ps
module fe_chip_model (
	// Control from the block
	input wire disc_phase,
	input wire [3:0] mux_select,
	// Discriminator and converter data
	output wire [31:0] disc_lines,
	output wire [9:0] adc_a,
	output wire [9:0] adc_b
);
	// Distinct halves so a swapped slot shows up
	assign disc_lines = disc_phase ? 32'hA5A50F0F : 32'h12345678;
	assign adc_a = {6'h00, mux_select};
	assign adc_b = {6'h20, mux_select};
endmodule // fe_chip_model

// *** tb/readout_asserts.sv ***
`timescale 1ns/10ps
module readout_asserts (
	// Clock and reset
	input wire clock,
	input wire resetn,
	// Watched ports
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire pready,
	input wire pslverr,
	input wire [3:0] gain_select,
	input wire [7:0] threshold,
	input wire amp_reset,
	input wire pipeline_freeze,
	input wire mux_clock,
	input wire adc_convert,
	input wire disc_phase,
	input wire readout_valid,
	input wire trig_packet_valid
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	apb_answer_a: assert property (psel && penable |-> pready && !pslverr)
		else $error("apb answer wrong");
	amp_pulse_a: assert property (amp_reset |=> !amp_reset)
		else $error("amp reset too long");
	conv_frozen_a: assert property (adc_convert |-> mux_clock && pipeline_freeze)
		else $error("convert without freeze");
	conv_gap_a: assert property (adc_convert |=> (!adc_convert) [*6])
		else $error("convert too fast");
	freeze_first_a: assert property ($rose(pipeline_freeze) |-> !adc_convert)
		else $error("convert before freeze");
	pkt_gap_a: assert property (trig_packet_valid |=> !trig_packet_valid)
		else $error("packets too close");
	disc_hold_a: assert property ($changed(disc_phase) |=> $stable(disc_phase) [*2])
		else $error("disc slot too short");
	gain_hold_a: assert property (!(psel && penable && pwrite) |=> $stable(gain_select))
		else $error("gain moved");
	thr_hold_a: assert property (!(psel && penable && pwrite) |=> $stable(threshold))
		else $error("threshold moved");
	byte_pulse_a: assert property (readout_valid |=> !readout_valid)
		else $error("byte strobe too long");
endmodule // readout_asserts
bind fiber_frontend_readout_emulator readout_asserts chk (.clock(clock), .resetn(resetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
	.gain_select(gain_select), .threshold(threshold), .amp_reset(amp_reset),
	.pipeline_freeze(pipeline_freeze), .mux_clock(mux_clock), .adc_convert(adc_convert),
	.disc_phase(disc_phase), .readout_valid(readout_valid),
	.trig_packet_valid(trig_packet_valid));

// *** tb/tb.sv ***
`timescale 1ns/10ps
`include "fiber_readout_defines.vh"
module tb;
	reg clock = 1'b0;
	reg resetn = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h00000000;
	reg [1:0] bus_mode = `MODE_CAPTURE;
	reg crossing = 1'b0;
	reg readout_step = 1'b0;
	wire [31:0] prdata, disc_lines;
	wire pready, pslverr, readout_valid, amp_reset, pipeline_freeze;
	wire mux_clock, disc_phase, adc_convert, trig_packet_valid;
	wire [7:0] readout_data, threshold;
	wire [3:0] gain_select, mux_select;
	wire [63:0] inject_mask;
	wire [9:0] adc_a, adc_b, trig_packet;
	integer mismatches = 0, comparisons = 0, pkts = 0, amps = 0, convs = 0, rcnt = 0, i;
	reg [9:0] pkt0;
	reg [7:0] rb [0:257];
	reg [31:0] q;
	always #5 clock = ~clock;
	fiber_frontend_readout_emulator uut (.clock(clock), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus_mode(bus_mode), .crossing(crossing),
		.readout_step(readout_step), .readout_data(readout_data),
		.readout_valid(readout_valid), .amp_reset(amp_reset), .gain_select(gain_select),
		.threshold(threshold), .inject_mask(inject_mask), .pipeline_freeze(pipeline_freeze),
		.mux_select(mux_select), .mux_clock(mux_clock), .disc_lines(disc_lines),
		.disc_phase(disc_phase), .adc_a(adc_a), .adc_b(adc_b), .adc_convert(adc_convert),
		.trig_packet(trig_packet), .trig_packet_valid(trig_packet_valid));
	fe_chip_model fe (.disc_phase(disc_phase), .mux_select(mux_select),
		.disc_lines(disc_lines), .adc_a(adc_a), .adc_b(adc_b));
	always @(posedge clock)
	begin
		if (trig_packet_valid === 1'b1 && pkts == 0)
			pkt0 = trig_packet;
		pkts = pkts + (trig_packet_valid === 1'b1);
		amps = amps + (amp_reset === 1'b1);
		convs = convs + (adc_convert === 1'b1);
		if (readout_valid === 1'b1 && rcnt < 258)
			rb[rcnt] = readout_data;
		rcnt = rcnt + (readout_valid === 1'b1);
	end
	task check(input string name, input logic [63:0] exp, input logic [63:0] got);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task t_regs;
		apb(0, `REG_CONTROL, 0);
		check("control", 32'h00001F00, q);
		apb(0, `REG_THRESHOLD, 0);
		check("threshold", 32'h00000080, q);
		apb(0, `REG_CHIP_ID, 0);
		check("chip id", 32'h0000005A, q);
		apb(1, 12'h03C, 32'hFFFFFFFF);
		apb(0, 12'h03C, 0);
		check("unmapped", 32'h00000000, q);
		// Tap 1 selects the row written last
		apb(1, `REG_CONTROL, 32'h0000011F);
		apb(1, `REG_THRESHOLD, 32'h0000003C);
		apb(1, `REG_INJECT_LO, 32'h89ABCDEF);
		apb(1, `REG_INJECT_HI, 32'h01234567);
		check("gain", 64'h000000000000000F, gain_select);
		check("thr out", 64'h000000000000003C, threshold);
		check("inject", 64'h0123456789ABCDEF, inject_mask);
	endtask
	task t_cross;
		pkts = 0;
		amps = 0;
		crossing <= 1'b1;
		repeat (4) @(posedge clock);
		crossing <= 1'b0;
		// Second rise lands mid-sequence and must be ignored
		repeat (4) @(posedge clock);
		crossing <= 1'b1;
		repeat (4) @(posedge clock);
		crossing <= 1'b0;
		for (i = 0; i < 300 && pkts < 8; i++)
			@(posedge clock);
		repeat (60) @(posedge clock);
		check("packets", 8, pkts);
		check("amp resets", 1, amps);
		check("packet 0", 64'h0000000000000278, pkt0);
	endtask
	task t_digitize;
		convs = 0;
		bus_mode <= `MODE_DIGITIZE;
		for (i = 0; i < 1000 && convs < 32; i++)
			@(posedge clock);
		check("digitize fast", 1, i < 250);
		repeat (40) @(posedge clock);
		check("conversions", 32, convs);
		check("freeze", 1, pipeline_freeze);
	endtask
	task t_readout;
		rcnt = 0;
		bus_mode <= `MODE_READOUT;
		repeat (6) @(posedge clock);
		for (i = 0; i < 260; i++)
		begin
			readout_step <= 1'b1;
			repeat (3) @(posedge clock);
			readout_step <= 1'b0;
			repeat (3) @(posedge clock);
		end
		check("bytes", 258, rcnt);
		check("first byte", 64'h000000000000005A, rb[0]);
		check("channel 0 id", 64'h0000000000000000, rb[2]);
		check("status byte", 64'h0000000000000031, rb[1]);
		check("disc ch 3", 64'h0000000000000001, rb[15]);
		check("disc ch 36", 64'h0000000000000000, rb[147]);
		check("channel 16 id", 64'h0000000000000010, rb[66]);
		check("float hi 16", 64'h0000000000000001, rb[68]);
		check("float lo 16", 64'h00000000000000C0, rb[69]);
		bus_mode <= `MODE_CAPTURE;
		for (i = 0; i < 20 && pipeline_freeze !== 1'b0; i++)
			@(posedge clock);
		check("unfreeze", 0, pipeline_freeze);
	endtask
	task print_verdict;
		if (mismatches == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		mismatches++;
		print_verdict;
	end
	initial
	begin
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		t_regs;
		t_cross;
		t_digitize;
		t_readout;
		print_verdict;
	end
endmodule // tb
